/* File: hdl/epiu_pkg.sv */
// Package of the external pin interrupt unit: register word indices,
// field positions, reset values, sense encodings and request vector slots.
// Assumes Avalon-MM word addressing; one register per 32-bit word.
package epiu_pkg;

   // Register word indices (byte address is four times the index)
   localparam logic [7:0] OFS_PIN_IRQ_FLAGS = 8'h3c;
   localparam logic [7:0] OFS_PIN_IRQ_ENABLE = 8'h3d;
   localparam logic [7:0] OFS_BANK_FLAGS = 8'h3b;
   localparam logic [7:0] OFS_BANK_CONTROL = 8'h68;
   localparam logic [7:0] OFS_SENSE_CONTROL = 8'h69;
   localparam logic [7:0] OFS_BANK_0_MASK = 8'h6b;
   localparam logic [7:0] OFS_BANK_1_MASK = 8'h6c;
   localparam logic [7:0] OFS_BANK_2_MASK = 8'h6d;

   // Reset values
   localparam logic [3:0] RST_SENSE = 4'h0;
   localparam logic [1:0] RST_LINE_EN = 2'h0;
   localparam logic [1:0] RST_LINE_FLAG = 2'h0;
   localparam logic [2:0] RST_BANK_EN = 3'h0;
   localparam logic [2:0] RST_BANK_FLAG = 3'h0;
   localparam logic [7:0] RST_MASK = 8'h00;

   // Field positions and widths
   localparam int SENSE_W = 2;
   localparam int LINE_A = 0;
   localparam int LINE_B = 1;
   localparam int NUM_LINES = 2;
   localparam int NUM_BANKS = 3;
   localparam int BANK_PINS = 8;
   localparam int BANK_1_PINS = 7;
   localparam int NUM_PC_PINS = 24;

   // Sense encodings of each line's two-bit field
   typedef enum logic [1:0] {
      EPIU_SENSE_LOW = 2'b00,
      EPIU_SENSE_ANY = 2'b01,
      EPIU_SENSE_FALL = 2'b10,
      EPIU_SENSE_RISE = 2'b11
   } epiu_sense_t;

   // Request vector slots toward the core
   localparam int VEC_LINE_A = 0;
   localparam int VEC_LINE_B = 1;
   localparam int VEC_BANK_0 = 2;
   localparam int VEC_BANK_1 = 3;
   localparam int VEC_BANK_2 = 4;
   localparam int NUM_VEC = 5;

   // Bus answer: one wait cycle on every access
   localparam int BUS_WAIT_CYCLES = 1;

endpackage : epiu_pkg

/* File: hdl/epiu_sync.sv */
// Two-stage synchroniser plus one history stage for a vector of pins.
// Assumes inputs are asynchronous; sync_o feeds logic, prev_o is one
// clock older so that edges can be found as sync_o against prev_o.
`timescale 1ns/10ps
`default_nettype none
module epiu_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o,
   output logic [W-1:0] prev_o
);

   logic [W-1:0] meta;

   // First stage is read only by the second; idle level of pins is high
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= '1;
         sync_o <= '1;
         prev_o <= '1;
      end else begin
         meta <= async_i;
         sync_o <= meta;
         prev_o <= sync_o;
      end
   end

endmodule : epiu_sync
`default_nettype wire

/* File: hdl/epiu_top.sv */
// External pin interrupt unit: two sensed interrupt lines, 24 pin-change
// inputs of which 23 sit in three banks (bit 15 in none), flags, enables and an Avalon-MM register slave.
// Assumes the core supplies its global interrupt bit and vector-entry
// acknowledges on ref_clk_i; pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
module epiu_top #(
   parameter int NUM_PINS = epiu_pkg::NUM_PC_PINS
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Avalon-MM slave, word addressed
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Pins and core side
   input wire logic ext_irq_line_a_i,
   input wire logic ext_irq_line_b_i,
   input wire logic [NUM_PINS-1:0] pin_change_inputs_i,
   input wire logic global_irq_enable_i,
   input wire logic [epiu_pkg::NUM_VEC-1:0] irq_ack_i,
   output logic [epiu_pkg::NUM_VEC-1:0] irq_req_o,
   output logic wake_o
);

   // Control and status state
   logic [3:0] sense_ctrl;
   logic [1:0] line_en;
   logic [1:0] line_flag;
   logic [2:0] bank_en;
   logic [2:0] bank_flag;
   logic [7:0] mask0;
   logic [6:0] mask1;
   logic [7:0] mask2;
   logic bus_ack;
   logic [31:0] next_readdata;
   logic [1:0] next_line_flag;
   logic [2:0] next_bank_flag;

   // Synchronised pins
   logic [1:0] line_raw;
   logic [1:0] line_s;
   logic [1:0] line_p;
   logic [NUM_PINS-1:0] pc_s;
   logic [NUM_PINS-1:0] pc_p;

   // Bus decode
   wire bus_req = avs_read_i | avs_write_i;
   wire wr_take = avs_write_i & bus_ack & avs_byteenable_i[0];
   wire [7:0] wbyte = avs_writedata_i[7:0];
   wire sel_sense = avs_address_i == epiu_pkg::OFS_SENSE_CONTROL;
   wire sel_line_en = avs_address_i == epiu_pkg::OFS_PIN_IRQ_ENABLE;
   wire sel_line_flag = avs_address_i == epiu_pkg::OFS_PIN_IRQ_FLAGS;
   wire sel_bank_en = avs_address_i == epiu_pkg::OFS_BANK_CONTROL;
   wire sel_bank_flag = avs_address_i == epiu_pkg::OFS_BANK_FLAGS;
   wire sel_mask0 = avs_address_i == epiu_pkg::OFS_BANK_0_MASK;
   wire sel_mask1 = avs_address_i == epiu_pkg::OFS_BANK_1_MASK;
   wire sel_mask2 = avs_address_i == epiu_pkg::OFS_BANK_2_MASK;

   // actual pin level
   // The port's input buffer feeds these, so output-driven pins still count
   assign line_raw = {ext_irq_line_b_i, ext_irq_line_a_i};

   // two-stage sync
   // Line pins: synchronised before any clocked detection
   epiu_sync #(
      .W(epiu_pkg::NUM_LINES)
   ) u_line_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i(line_raw),
      .sync_o(line_s),
      .prev_o(line_p)
   );

   // sample before edges
   // Pin-change inputs share the same synchroniser structure
   epiu_sync #(
      .W(NUM_PINS)
   ) u_pc_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i(pin_change_inputs_i),
      .sync_o(pc_s),
      .prev_o(pc_p)
   );

   // Line events by sense mode
   logic [1:0] line_event;
   logic [1:0] line_level_mode;
   logic [1:0] line_low_req;

   genvar gi;
   generate
      for (gi = 0; gi < epiu_pkg::NUM_LINES; gi++) begin : g_line
         wire [1:0] mode = sense_ctrl[gi*epiu_pkg::SENSE_W +: epiu_pkg::SENSE_W];
         wire ev_any = line_s[gi] ^ line_p[gi];
         wire ev_fall = line_p[gi] & ~line_s[gi];
         wire ev_rise = line_s[gi] & ~line_p[gi];
         assign line_level_mode[gi] = mode == epiu_pkg::EPIU_SENSE_LOW;
         assign line_event[gi] = (mode == epiu_pkg::EPIU_SENSE_ANY) ? ev_any :
                                 (mode == epiu_pkg::EPIU_SENSE_FALL) ? ev_fall :
                                 (mode == epiu_pkg::EPIU_SENSE_RISE) ? ev_rise : 1'b0;
         // level request
         // Held while the synchronised pin stays low; no flag involved
         assign line_low_req[gi] = line_level_mode[gi] & ~line_s[gi];
      end
   endgenerate

   // Bank change detection
   wire [NUM_PINS-1:0] pc_toggle = pc_s ^ pc_p;
   wire [23:0] pc_mask = {mask2, 1'b0, mask1, mask0};
   wire [23:0] pc_hit = pc_toggle[23:0] & pc_mask;
   wire bank0_event = |pc_hit[7:0];
   wire bank1_event = |pc_hit[14:8];
   wire bank2_event = |pc_hit[23:16];
   wire [2:0] bank_event = {bank2_event, bank1_event, bank0_event};

   // Write-one-to-clear strobes
   wire [1:0] line_w1c = (wr_take & sel_line_flag) ? wbyte[1:0] : 2'b00;
   wire [2:0] bank_w1c = (wr_take & sel_bank_flag) ? wbyte[2:0] : 3'b000;
   wire [1:0] line_ack = {irq_ack_i[epiu_pkg::VEC_LINE_B], irq_ack_i[epiu_pkg::VEC_LINE_A]};
   wire [2:0] bank_ack = {irq_ack_i[epiu_pkg::VEC_BANK_2], irq_ack_i[epiu_pkg::VEC_BANK_1],
                          irq_ack_i[epiu_pkg::VEC_BANK_0]};

   // Next line flags: a new event wins over a clear in the same cycle
   always_comb begin
      for (int i = 0; i < epiu_pkg::NUM_LINES; i++) begin
         if (line_level_mode[i]) begin
            next_line_flag[i] = 1'b0;
         end else if (line_event[i]) begin
            next_line_flag[i] = 1'b1;
         end else if (line_ack[i] | line_w1c[i]) begin
            next_line_flag[i] = 1'b0;
         end else begin
            next_line_flag[i] = line_flag[i];
         end
      end
   end

   // bank flag set and clear
   // Set wins over a clear arriving in the same cycle
   assign next_bank_flag = bank_event | (bank_flag & ~(bank_ack | bank_w1c));

   // Flag registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_flag <= epiu_pkg::RST_LINE_FLAG;
         bank_flag <= epiu_pkg::RST_BANK_FLAG;
      end else begin
         line_flag <= next_line_flag;
         bank_flag <= next_bank_flag;
      end
   end

   // Software-written control registers, applied at the accepting edge
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sense_ctrl <= epiu_pkg::RST_SENSE;
         line_en <= epiu_pkg::RST_LINE_EN;
         bank_en <= epiu_pkg::RST_BANK_EN;
      end else if (wr_take) begin
         if (sel_sense) sense_ctrl <= wbyte[3:0];
         if (sel_line_en) line_en <= wbyte[1:0];
         if (sel_bank_en) bank_en <= wbyte[2:0];
      end
   end

   // Mask registers kept apart to keep each process short
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask0 <= epiu_pkg::RST_MASK;
         mask1 <= epiu_pkg::RST_MASK[6:0];
         mask2 <= epiu_pkg::RST_MASK;
      end else if (wr_take) begin
         if (sel_mask0) mask0 <= wbyte;
         if (sel_mask1) mask1 <= wbyte[6:0];
         if (sel_mask2) mask2 <= wbyte;
      end
   end

   // Requests to the core's vector logic
   // line enable and global
   assign irq_req_o[epiu_pkg::VEC_LINE_A] = global_irq_enable_i & line_en[epiu_pkg::LINE_A] &
      (line_low_req[epiu_pkg::LINE_A] | line_flag[epiu_pkg::LINE_A]);
   assign irq_req_o[epiu_pkg::VEC_LINE_B] = global_irq_enable_i & line_en[epiu_pkg::LINE_B] &
      (line_low_req[epiu_pkg::LINE_B] | line_flag[epiu_pkg::LINE_B]);
   assign irq_req_o[epiu_pkg::VEC_BANK_0] = global_irq_enable_i & bank_en[0] & bank_flag[0];
   assign irq_req_o[epiu_pkg::VEC_BANK_1] = global_irq_enable_i & bank_en[1] & bank_flag[1];
   assign irq_req_o[epiu_pkg::VEC_BANK_2] = global_irq_enable_i & bank_en[2] & bank_flag[2];

   // Unclocked wake path: raw pins against the last synchronised value.
   // With the clock stopped that value is frozen, so any change on a masked-in pin of an enabled bank shows at once.
   // clockless pin change
   wire [23:0] pc_diff = (pin_change_inputs_i[23:0] ^ pc_s[23:0]) & pc_mask;
   wire pc_wake = (|pc_diff[7:0] & bank_en[0]) | (|pc_diff[14:8] & bank_en[1]) |
                  (|pc_diff[23:16] & bank_en[2]);
   // wake without request
   // A short low wakes the part, but the clocked request path may never see it
   wire lvl_wake_a = line_en[epiu_pkg::LINE_A] & line_level_mode[epiu_pkg::LINE_A] &
                     ~ext_irq_line_a_i;
   wire lvl_wake_b = line_en[epiu_pkg::LINE_B] & line_level_mode[epiu_pkg::LINE_B] &
                     ~ext_irq_line_b_i;
   assign wake_o = pc_wake | lvl_wake_a | lvl_wake_b;

   // unused bits zero
   // Read mux; unmapped words read as zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (sel_sense) next_readdata[3:0] = sense_ctrl;
      if (sel_line_en) next_readdata[1:0] = line_en;
      if (sel_line_flag) next_readdata[1:0] = line_flag;
      if (sel_bank_en) next_readdata[2:0] = bank_en;
      if (sel_bank_flag) next_readdata[2:0] = bank_flag;
      if (sel_mask0) next_readdata[7:0] = mask0;
      if (sel_mask1) next_readdata[6:0] = mask1;
      if (sel_mask2) next_readdata[7:0] = mask2;
   end

   // Bus handshake: one wait cycle, so read data come from a flip-flop
   assign avs_waitrequest_o = bus_req & ~bus_ack;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_ack <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read_i & ~bus_ack) avs_readdata_o <= next_readdata;
      end
   end

endmodule : epiu_top
`default_nettype wire

/* File: tb/epiu_pin_source.sv */
// Model of the outside sources on the interrupt pins.
// Assumes the bench sets wanted levels; pins move only at clock edges.
`timescale 1ns/10ps
`default_nettype none
module epiu_pin_source (
   input wire logic ref_clk_i,
   input wire logic want_a_i,
   input wire logic want_b_i,
   input wire logic [23:0] want_pc_i,
   output logic line_a_o = 1'b1,
   output logic line_b_o = 1'b1,
   output logic [23:0] pc_o = 24'hffffff
);
   always_ff @(posedge ref_clk_i) begin
      line_a_o <= want_a_i;
      line_b_o <= want_b_i;
      pc_o <= want_pc_i;
   end
endmodule : epiu_pin_source
`default_nettype wire

/* File: tb/epiu_properties.sv */
// Checker of the pin interrupt unit: bus answer timing, global gating,
// request causes and flag clears. Assumes binding to epiu_top ports only.
`timescale 1ns/10ps
`default_nettype none
module epiu_properties #(
   parameter int NUM_PINS = 24
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic ext_irq_line_a_i,
   input wire logic [NUM_PINS-1:0] pin_change_inputs_i,
   input wire logic global_irq_enable_i,
   input wire logic [4:0] irq_ack_i,
   input wire logic [4:0] irq_req_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // Bank slices; bit 15 is left out on purpose
   wire logic [7:0] pc0 = pin_change_inputs_i[7:0];
   wire logic [6:0] pc1 = pin_change_inputs_i[14:8];
   wire logic [7:0] pc2 = pin_change_inputs_i[23:16];
   wire logic [23:0] pca = pin_change_inputs_i[23:0];
   wire logic mapped = avs_address_i inside {epiu_pkg::OFS_PIN_IRQ_FLAGS, epiu_pkg::OFS_PIN_IRQ_ENABLE,
      epiu_pkg::OFS_BANK_FLAGS, epiu_pkg::OFS_BANK_CONTROL, epiu_pkg::OFS_SENSE_CONTROL,
      epiu_pkg::OFS_BANK_0_MASK, epiu_pkg::OFS_BANK_1_MASK, epiu_pkg::OFS_BANK_2_MASK};
   // A request rising without a register write or global change must come from a pin
   AST_ONE_WAIT: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after exactly one wait cycle");
   AST_IDLE_NO_WAIT: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high with no request");
   AST_UNUSED_ZERO: assert property (avs_read_i && !avs_waitrequest_o |->
      avs_readdata_o[31:8] == 24'h000000 && (mapped || avs_readdata_o == 32'h00000000))
      else $error("unused read bits not zero");
   AST_GLOBAL_GATE: assert property (!global_irq_enable_i |-> irq_req_o == 5'h00)
      else $error("request while global bit clear");
   AST_BANK0_CAUSE: assert property ($rose(irq_req_o[2]) && $stable(global_irq_enable_i) && !$past(avs_write_i)
      |-> $past(pc0, 3) != $past(pc0, 4)) else $error("bank 0 request without pin toggle");
   AST_BANK1_CAUSE: assert property ($rose(irq_req_o[3]) && $stable(global_irq_enable_i) && !$past(avs_write_i)
      |-> $past(pc1, 3) != $past(pc1, 4)) else $error("bank 1 request without pin toggle");
   AST_BANK2_CAUSE: assert property ($rose(irq_req_o[4]) && $stable(global_irq_enable_i) && !$past(avs_write_i)
      |-> $past(pc2, 3) != $past(pc2, 4)) else $error("bank 2 request without pin toggle");
   AST_LINE_A_CAUSE: assert property ($rose(irq_req_o[0]) && $stable(global_irq_enable_i) && !$past(avs_write_i)
      |-> $past(ext_irq_line_a_i, 3) != $past(ext_irq_line_a_i, 4) || $past(ext_irq_line_a_i, 2) != $past(ext_irq_line_a_i, 3))
      else $error("line a request without pin activity");
   AST_BANK_ACK_CLEAR: assert property (irq_ack_i[4:2] != 3'h0 && $stable(pca) && $past(pca) == $past(pca, 2) &&
      $past(pca, 2) == $past(pca, 3) |=> (irq_req_o[4:2] & $past(irq_ack_i[4:2])) == 3'h0)
      else $error("bank request kept after vector entry");
   AST_LINE_ACK_CLEAR: assert property (irq_ack_i[0] && ext_irq_line_a_i && $past(ext_irq_line_a_i) &&
      $past(ext_irq_line_a_i, 2) && $past(ext_irq_line_a_i, 3) |=> !irq_req_o[0])
      else $error("line a request kept after vector entry");
   COV_READ: cover property (avs_read_i && !avs_waitrequest_o);
   COV_BANK_REQ: cover property ($rose(irq_req_o[4]));
   COV_LINE_REQ: cover property ($rose(irq_req_o[1]));
endmodule : epiu_properties
bind epiu_top epiu_properties #(.NUM_PINS(NUM_PINS)) u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .ext_irq_line_a_i(ext_irq_line_a_i),
   .pin_change_inputs_i(pin_change_inputs_i), .global_irq_enable_i(global_irq_enable_i),
   .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o));
`default_nettype wire

/* File: tb/epiu_top_test.sv */
// Bench of the pin interrupt unit: register map, sense modes, gating, banks.
// Assumes epiu_top, the pin source model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module epiu_top_test;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] address = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic glb = 1'b0;
   logic [4:0] ack = 5'h00;
   logic want_a = 1'b1;
   logic want_b = 1'b1;
   logic [23:0] want_pc = 24'hffffff;
   logic strobe = 1'b0;
   logic wstrobe = 1'b0;
   wire logic [31:0] rdata;
   wire logic wait_req;
   wire logic [4:0] req;
   wire logic wake;
   wire logic line_a;
   wire logic line_b;
   wire logic [23:0] pc;
   int num_errors = 0;
   int n_compared = 0;
   logic [31:0] q_rd[$];
   logic [4:0] q_irq[$];
   logic q_wake[$];
   localparam logic [7:0] REGS [8] = '{epiu_pkg::OFS_PIN_IRQ_FLAGS, epiu_pkg::OFS_PIN_IRQ_ENABLE,
      epiu_pkg::OFS_BANK_FLAGS, epiu_pkg::OFS_BANK_CONTROL, epiu_pkg::OFS_SENSE_CONTROL,
      epiu_pkg::OFS_BANK_0_MASK, epiu_pkg::OFS_BANK_1_MASK, epiu_pkg::OFS_BANK_2_MASK};
   localparam logic [31:0] WMASK [8] = '{32'h0, 32'h3, 32'h0, 32'h7, 32'hf, 32'hff, 32'h7f, 32'hff};
   epiu_top dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .avs_address_i(address), .avs_read_i(rd_en),
      .avs_write_i(wr_en), .avs_byteenable_i(4'h1), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_req), .ext_irq_line_a_i(line_a), .ext_irq_line_b_i(line_b),
      .pin_change_inputs_i(pc), .global_irq_enable_i(glb), .irq_ack_i(ack), .irq_req_o(req), .wake_o(wake));
   epiu_pin_source src (.ref_clk_i(ref_clk), .want_a_i(want_a), .want_b_i(want_b), .want_pc_i(want_pc),
      .line_a_o(line_a), .line_b_o(line_b), .pc_o(pc));
   // Free-running clock, 50 ns period
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic cmp_rd(input logic [31:0] e);
      n_compared++;
      if (rdata !== e) begin
         num_errors++;
         $display("mismatch at %0t: readdata %h, expected %h", $time, rdata, e);
      end
   endtask : cmp_rd
   task automatic cmp_irq(input logic [4:0] e);
      n_compared++;
      if (req !== e) begin
         num_errors++;
         $display("mismatch at %0t: requests %b, expected %b", $time, req, e);
      end
   endtask : cmp_irq
   task automatic cmp_wake(input logic e);
      n_compared++;
      if (wake !== e) begin
         num_errors++;
         $display("mismatch at %0t: wake %b, expected %b", $time, wake, e);
      end
   endtask : cmp_wake
   // Request held until waitrequest is seen low; the wait is bounded
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      rd_en <= ~w;
      wr_en <= w;
      address <= a;
      wdata <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wait_req !== 1'b0 && n < 20);
      if (wait_req !== 1'b0) begin
         num_errors++;
         tally_and_finish();
      end
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask : rd
   task automatic chk(input logic [4:0] e);
      q_irq.push_back(e);
      @(posedge ref_clk);
      strobe <= 1'b1;
      @(posedge ref_clk);
      strobe <= 1'b0;
   endtask : chk
   // Wake is unclocked and may stand only two cycles after a pin moves
   task automatic chk_wake(input logic e);
      q_wake.push_back(e);
      @(posedge ref_clk);
      wstrobe <= 1'b1;
      @(posedge ref_clk);
      wstrobe <= 1'b0;
   endtask : chk_wake
   task automatic pulse(input logic [4:0] v);
      @(posedge ref_clk);
      ack <= v;
      @(posedge ref_clk);
      ack <= 5'h00;
   endtask : pulse
   // Monitor: oldest note is compared whenever a result shows
   always @(posedge ref_clk) begin
      if (rd_en && wait_req === 1'b0 && q_rd.size() > 0) cmp_rd(q_rd.pop_front());
      if (strobe && q_irq.size() > 0) cmp_irq(q_irq.pop_front());
      if (wstrobe && q_wake.size() > 0) cmp_wake(q_wake.pop_front());
   end
   initial begin
      int m;
      int k;
      int p;
      int o;
      void'($urandom(32'h3a1827e0));
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      for (k = 0; k < 8; k++) rd(REGS[k], 32'h0);
      rd(8'h10, 32'h0);
      // Writing all ones shows which bits exist; masks then cleared again
      for (k = 0; k < 8; k++) begin
         wr(REGS[k], 8'hff);
         rd(REGS[k], WMASK[k]);
      end
      for (k = 5; k < 8; k++) wr(REGS[k], 8'h00);
      glb <= 1'b1;
      // Every sense code on both lines: fall phase then rise phase
      for (m = 0; m < 4; m++) begin
         wr(epiu_pkg::OFS_SENSE_CONTROL, {4'h0, 2'(m), 2'(m)});
         wr(epiu_pkg::OFS_PIN_IRQ_FLAGS, 8'h03);
         want_a <= 1'b0;
         want_b <= 1'b0;
         repeat (6) @(posedge ref_clk);
         chk({3'h0, {2{m != 3}}});
         chk_wake(m == 0);
         rd(epiu_pkg::OFS_PIN_IRQ_FLAGS, (m == 1 || m == 2) ? 32'h3 : 32'h0);
         wr(epiu_pkg::OFS_PIN_IRQ_FLAGS, 8'h03);
         chk({3'h0, {2{m == 0}}});
         want_a <= 1'b1;
         want_b <= 1'b1;
         repeat (6) @(posedge ref_clk);
         chk({3'h0, {2{m == 1 || m == 3}}});
         pulse(5'h03);
         chk(5'h00);
      end
      // Enable bits and global bit gate a pending flag
      wr(epiu_pkg::OFS_SENSE_CONTROL, 8'h0a);
      want_a <= 1'b0;
      want_b <= 1'b0;
      wr(epiu_pkg::OFS_PIN_IRQ_ENABLE, 8'h01);
      chk(5'h01);
      glb <= 1'b0;
      chk(5'h00);
      glb <= 1'b1;
      wr(epiu_pkg::OFS_PIN_IRQ_ENABLE, 8'h03);
      chk(5'h03);
      wr(epiu_pkg::OFS_PIN_IRQ_FLAGS, 8'h03);
      want_a <= 1'b1;
      want_b <= 1'b1;
      // One random pin per bank; a masked-off neighbour must stay silent
      for (k = 0; k < 3; k++) begin
         p = (k == 1) ? 8 + $urandom % 7 : 8 * k + $urandom % 8;
         o = (k == 1) ? 8 + (p - 7) % 7 : 8 * k + (p - 8 * k + 1) % 8;
         wr(8'(epiu_pkg::OFS_BANK_0_MASK + k), 8'(1 << (p - 8 * k)));
         want_pc[o] <= ~want_pc[o];
         chk_wake(1'b0);
         repeat (6) @(posedge ref_clk);
         chk(5'h00);
         want_pc[p] <= ~want_pc[p];
         chk_wake(1'b1);
         repeat (6) @(posedge ref_clk);
         chk(5'(1 << (epiu_pkg::VEC_BANK_0 + k)));
         rd(epiu_pkg::OFS_BANK_FLAGS, 32'(1 << k));
         if (k == 0) wr(epiu_pkg::OFS_BANK_FLAGS, 8'h01);
         else pulse(5'(1 << (epiu_pkg::VEC_BANK_0 + k)));
         chk(5'h00);
         wr(8'(epiu_pkg::OFS_BANK_0_MASK + k), 8'h00);
      end
      tally_and_finish();
   end
endmodule : epiu_top_test
`default_nettype wire
